// [include/status_pkg.sv]
// Purpose: constants and types for the output status logic
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: option codes select the function driven onto a terminal
//
// What this block does
// RL1 - Two operands, one operator: AND, OR, XOR
// RL2 - Operands exclude the three combined outputs
// RL3 - Three combined outputs, option codes 33-35
// RL4 - Output high exactly when operation gives one
// RL5 - Any terminal may carry a combined result
// RL6 - Option 39 flags expired capacitor life
// RL7 - Option 40 flags fan at 75 percent
// RL8 - Fan control setting 01 suppresses fan warning
// RL9 - Both warnings readable as monitor item
// RL10 - Starting contact ignores run command source
// RL11 - Contact on for one or no command
// RL12 - Both commands: stop motor, contact off
// RL13 - Combined outputs evaluated and registered each cycle
package status_pkg;

   // Signal set width: codes 0..63
   localparam int SIG_W = 6;
   localparam int NUM_SIGS = 64;
   localparam int NUM_TERMS = 3; // two transistor outputs and the relay

   // Option codes
   localparam logic [5:0] OPT_COMBINED_ONE = 6'h21;   // 33
   localparam logic [5:0] OPT_COMBINED_TWO = 6'h22;   // 34
   localparam logic [5:0] OPT_COMBINED_THREE = 6'h23; // 35
   localparam logic [5:0] OPT_CAP_WARN = 6'h27;       // 39
   localparam logic [5:0] OPT_FAN_WARN = 6'h28;       // 40
   localparam logic [5:0] OPT_START_CONTACT = 6'h29;  // 41

   // Fan speed threshold, percent of full speed
   localparam int FAN_PCT = 75;
   localparam logic [1:0] FAN_CTRL_SUPPRESS = 2'h1;
   localparam logic [1:0] FAN_CTRL_RESET = 2'h0;

   // Register map
   localparam logic [3:0] ADDR_COMB_ONE = 4'h0;
   localparam logic [3:0] ADDR_COMB_TWO = 4'h1;
   localparam logic [3:0] ADDR_COMB_THREE = 4'h2;
   localparam logic [3:0] ADDR_TERM_SEL = 4'h3;
   localparam logic [3:0] ADDR_FAN_CTRL = 4'h4;
   localparam logic [3:0] ADDR_MONITOR = 4'h5;
   localparam logic [3:0] ADDR_TERM_STATE = 4'h6;

   // Combined output config field positions
   localparam int CFG_A_LSB = 0;
   localparam int CFG_B_LSB = 8;
   localparam int CFG_OP_LSB = 16;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [17:0] TERM_SEL_RESET = 18'h00000;

   typedef enum logic [1:0] {
      OP_AND = 2'h0,
      OP_OR = 2'h1,
      OP_XOR = 2'h2
   } comb_op_t;

   typedef struct packed {
      comb_op_t op;
      logic [SIG_W-1:0] sel_b;
      logic [SIG_W-1:0] sel_a;
   } comb_cfg_t;

   typedef struct packed {
      logic fan_warn;
      logic cap_warn;
   } life_warn_t;

endpackage : status_pkg

// [logic/combined_unit.sv]
// Purpose: one combined logic output
// Assumes: operand vector excludes combined outputs
// Notes: result registered once per clock
`timescale 1ns/100ps
module combined_unit
   import status_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire comb_cfg_t cfg,
   input wire logic [NUM_SIGS-1:0] sigs,
   output logic result
);
   logic op_a;
   logic op_b;
   logic result_next;

   // Operand pick and operator
   always_comb begin
      op_a = sigs[cfg.sel_a]; // RL1
      op_b = sigs[cfg.sel_b];
      case (cfg.op)
         OP_AND: result_next = op_a & op_b; // RL4
         OP_OR: result_next = op_a | op_b;
         OP_XOR: result_next = op_a ^ op_b;
         default: result_next = 1'b0; // Unused code keeps output off
      endcase
   end

   // One register stage before the terminal mux
   always_ff @(posedge clk) begin
      if (srst) begin
         result <= 1'b0;
      end else begin
         result <= result_next; // RL13
      end
   end
endmodule : combined_unit

// [logic/output_status_logic.sv]
// Purpose: terminal status functions of the drive
// Assumes: inputs synchronous to clk; plain register port
// Notes: other output functions arrive on other_sigs
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module output_status_logic
   import status_pkg::*;
#(
   parameter int FAN_SPEED_W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [NUM_SIGS-1:0] other_sigs,
   input wire logic cap_life_expired,
   input wire logic [FAN_SPEED_W-1:0] fan_speed,
   input wire logic [FAN_SPEED_W-1:0] fan_full_speed,
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   output logic [NUM_TERMS-1:0] terminal_out,
   output logic motor_stop,
   output logic starting_contact
);
   // Refuse widths the scaled speed compare cannot hold
   if (FAN_SPEED_W < 2 || FAN_SPEED_W > 24) begin : g_bad_width
      $error("FAN_SPEED_W out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers

   comb_cfg_t comb_cfg_reg [3];
   logic [17:0] term_sel_reg;
   logic [1:0] fan_control_setting_reg;

   // Software writes, one register per strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 3; i++) begin
            comb_cfg_reg[i] <= comb_cfg_t'(CFG_RESET[$bits(comb_cfg_t)-1:0]);
         end
         term_sel_reg <= TERM_SEL_RESET;
         fan_control_setting_reg <= FAN_CTRL_RESET;
      end else if (wr) begin
         case (addr)
            ADDR_COMB_ONE, ADDR_COMB_TWO, ADDR_COMB_THREE: begin
               comb_cfg_reg[addr[1:0]] <= '{op: comb_op_t'(wdata[CFG_OP_LSB +: 2]),
                  sel_b: wdata[CFG_B_LSB +: SIG_W], sel_a: wdata[CFG_A_LSB +: SIG_W]};
            end
            ADDR_TERM_SEL: term_sel_reg <= wdata[17:0];
            ADDR_FAN_CTRL: fan_control_setting_reg <= wdata[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Lifetime warnings

   life_warn_t warn_reg;
   logic fan_slow;
   logic [FAN_SPEED_W+6:0] speed_scaled;
   logic [FAN_SPEED_W+6:0] full_scaled;

   // Multiply instead of divide: speed*100 <= full*75
   assign speed_scaled = (FAN_SPEED_W+7)'(fan_speed) * (FAN_SPEED_W+7)'(100);
   assign full_scaled = (FAN_SPEED_W+7)'(fan_full_speed) * (FAN_SPEED_W+7)'(FAN_PCT);
   assign fan_slow = speed_scaled <= full_scaled; // RL7

   always_ff @(posedge clk) begin
      if (srst) begin
         warn_reg <= '0;
      end else begin
         warn_reg.cap_warn <= cap_life_expired; // RL6
         // Stopped fan is expected when the control setting allows it
         warn_reg.fan_warn <= fan_slow && (fan_control_setting_reg != FAN_CTRL_SUPPRESS); // RL8
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Starting contact and run conflict

   logic both_cmds;
   assign both_cmds = forward_run_command & reverse_run_command;

   // Source setting is not consulted at all
   always_ff @(posedge clk) begin
      if (srst) begin
         starting_contact <= 1'b1;
         motor_stop <= 1'b0;
      end else begin
         starting_contact <= ~both_cmds; // RL10 RL11
         motor_stop <= both_cmds; // RL12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Combined outputs

   logic [NUM_SIGS-1:0] operand_sigs;
   logic [NUM_SIGS-1:0] all_sigs;
   logic [2:0] comb_result;

   // Own functions overlay the external set; combined codes forced low
   always_comb begin
      operand_sigs = other_sigs;
      operand_sigs[OPT_CAP_WARN] = warn_reg.cap_warn;
      operand_sigs[OPT_FAN_WARN] = warn_reg.fan_warn;
      operand_sigs[OPT_START_CONTACT] = starting_contact;
      operand_sigs[OPT_COMBINED_ONE] = 1'b0; // RL2
      operand_sigs[OPT_COMBINED_TWO] = 1'b0;
      operand_sigs[OPT_COMBINED_THREE] = 1'b0;
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_comb
         combined_unit u_comb (
            .clk(clk),
            .srst(srst),
            .cfg(comb_cfg_reg[g]),
            .sigs(operand_sigs),
            .result(comb_result[g])
         ); // RL1 RL3
      end
   endgenerate

   // Terminal view includes combined results at their codes
   always_comb begin
      all_sigs = operand_sigs;
      all_sigs[OPT_COMBINED_ONE] = comb_result[0]; // RL3
      all_sigs[OPT_COMBINED_TWO] = comb_result[1];
      all_sigs[OPT_COMBINED_THREE] = comb_result[2];
   end

   ////////////////////////////////////////////////////////////////////
   // Terminal selection

   logic [NUM_TERMS-1:0] term_pick;

   // Each terminal picks one code from the full function set
   generate
      for (g = 0; g < NUM_TERMS; g++) begin : g_term
         assign term_pick[g] = all_sigs[term_sel_reg[g*SIG_W +: SIG_W]]; // RL5
      end
   endgenerate

   // One process owns all terminal bits, so no bit has two writers
   always_ff @(posedge clk) begin
      if (srst) begin
         terminal_out <= '0;
      end else begin
         terminal_out <= term_pick;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read port, data in the cycle after the strobe

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            ADDR_COMB_ONE, ADDR_COMB_TWO, ADDR_COMB_THREE: begin
               rdata <= {14'h0000, comb_cfg_reg[addr[1:0]].op, 2'h0,
                  comb_cfg_reg[addr[1:0]].sel_b, 2'h0, comb_cfg_reg[addr[1:0]].sel_a};
            end
            ADDR_TERM_SEL: rdata <= {14'h0000, term_sel_reg};
            ADDR_FAN_CTRL: rdata <= {30'h00000000, fan_control_setting_reg};
            ADDR_MONITOR: rdata <= {30'h00000000, warn_reg}; // RL9
            ADDR_TERM_STATE: rdata <= {26'h0000000, motor_stop, starting_contact,
               comb_result, 1'b0};
            default: rdata <= 32'h0000_0000; // Unmapped reads zero
         endcase
      end else begin
         rdata <= 32'h0000_0000; // Data valid only in the answer cycle
      end
   end
endmodule : output_status_logic

// [tb/output_status_logic_props.sv]
// Purpose: port timing checks for the status block
// Assumes: one clock, srst synchronous
// Notes: bound to every instance
`timescale 1ns/100ps
module output_status_logic_props
   import status_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] addr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic cap_life_expired,
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   input wire logic motor_stop,
   input wire logic starting_contact
);
   ////////////////////////////////////////////////////////////////
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic both;
   assign both = forward_run_command && reverse_run_command;
   // Contact and stop follow the commands one cycle later
   chk_contact_on: assert property (!both |=> starting_contact)
      else $error("contact low");
   chk_contact_off: assert property (both |=> !starting_contact)
      else $error("contact high");
   chk_stop_set: assert property (both |=> motor_stop)
      else $error("no stop");
   chk_stop_clear: assert property (!both |=> !motor_stop)
      else $error("stray stop");
   chk_stop_excl: assert property (motor_stop |-> !starting_contact)
      else $error("stop with contact");
   // Read data stand only in the cycle after a read
   chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
      else $error("rdata not idle");
   // Monitor bit lags the warning input by two stages
   chk_cap_set: assert property (cap_life_expired [*3] ##0 (rd && addr == ADDR_MONITOR)
      |=> rdata[0])
      else $error("cap warn missing");
   chk_cap_clear: assert property (!cap_life_expired [*3] ##0 (rd && addr == ADDR_MONITOR)
      |=> !rdata[0])
      else $error("cap warn stray");
   chk_state_contact: assert property (rd && addr == ADDR_TERM_STATE
      |=> rdata[4] == $past(starting_contact))
      else $error("state contact");
endmodule : output_status_logic_props
bind output_status_logic output_status_logic_props chk (.clk, .srst, .addr, .rd, .rdata,
   .cap_life_expired, .forward_run_command, .reverse_run_command, .motor_stop,
   .starting_contact);

// [tb/terminal_load.sv]
// Purpose: loads on the two transistor outputs and relay
// Assumes: high drive energizes a load
// Notes: a coil lags its drive by one cycle
`timescale 1ns/100ps
module terminal_load (
   input wire logic clk,
   input wire logic [2:0] drive,
   output logic [2:0] energized
);
   // Slow coil, so the bench never sees the drive edge itself
   always_ff @(posedge clk) begin
      energized <= drive;
   end
endmodule : terminal_load

// [tb/output_status_logic_bench.sv]
// Purpose: self-checking bench for the status block
// Assumes: 50 MHz clock, register port reads one cycle late
// Notes: terminals 0,1,2 carry combined one, two, contact
`timescale 1ns/100ps
module output_status_logic_bench
   import status_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, e;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [63:0] other_sigs = 64'h0;
   logic cap_life_expired = 1'b0, motor_stop, starting_contact;
   logic [15:0] fan_speed = 16'h0064, fan_full_speed = 16'h0064;
   logic forward_run_command = 1'b0, reverse_run_command = 1'b0;
   logic [2:0] terminal_out, energized;
   int num_errors = 0, checks = 0, cyc = 0;
   ////////////////////////////////////////////////////////////////
   output_status_logic uut (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .other_sigs,
      .cap_life_expired, .fan_speed, .fan_full_speed, .forward_run_command,
      .reverse_run_command, .terminal_out, .motor_stop, .starting_contact);
   terminal_load load (.clk, .drive(terminal_out), .energized);
   initial begin
      forever #10 clk = ~clk;
   end
   // Cut a hang short well past the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Masked compare of the word in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, x);
   endtask : rd_chk
   // Longest path: operand to coil is three cycles, settle waits four
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle
   task automatic summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      wr_reg(ADDR_TERM_SEL, {14'h0, OPT_START_CONTACT, OPT_COMBINED_TWO, OPT_COMBINED_ONE});
      // Every operator over all operand pairs, codes 1 and 2
      for (int op = 0; op < 3; op++) begin
         wr_reg(ADDR_COMB_ONE, {14'h0, op[1:0], 8'h02, 8'h01});
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            other_sigs[2:1] <= k[1:0];
            settle();
            e = (op == 0) ? k[0] & k[1] : (op == 1) ? k[0] | k[1] : k[0] ^ k[1];
            rd_chk(ADDR_TERM_STATE, 32'h2, {30'h0, e, 1'b0});
            chk({31'h0, energized[0]}, {31'h0, e});
         end
      end
      // Combined one is high; selecting its code must still read low
      @(posedge clk);
      other_sigs <= 64'h0000_0002_0000_0002;
      wr_reg(ADDR_COMB_TWO, 32'h0001_0021);
      settle();
      rd_chk(ADDR_TERM_STATE, 32'he, 32'h2);
      wr_reg(ADDR_COMB_TWO, 32'h0001_0001);
      wr_reg(ADDR_COMB_THREE, 32'h0002_0201);
      settle();
      rd_chk(ADDR_TERM_STATE, 32'he, 32'he);
      chk({31'h0, energized[1]}, 32'h1);
      rd_chk(ADDR_TERM_SEL, 32'hffff_ffff,
         {14'h0, OPT_START_CONTACT, OPT_COMBINED_TWO, OPT_COMBINED_ONE});
      // Unused operator code must read low even where OR would give one
      wr_reg(ADDR_COMB_THREE, 32'h0003_0101);
      settle();
      rd_chk(ADDR_TERM_STATE, 32'h8, 32'h0);
      rd_chk(ADDR_COMB_THREE, 32'hffff_ffff, 32'h0003_0101);
      // Fan boundary at exactly 75 of 100, then suppression
      @(posedge clk);
      cap_life_expired <= 1'b1;
      fan_speed <= 16'h004b;
      settle();
      rd_chk(ADDR_MONITOR, 32'h3, 32'h3);
      @(posedge clk);
      cap_life_expired <= 1'b0;
      fan_speed <= 16'h004c;
      settle();
      rd_chk(ADDR_MONITOR, 32'h3, 32'h0);
      wr_reg(ADDR_FAN_CTRL, {30'h0, FAN_CTRL_SUPPRESS});
      rd_chk(ADDR_FAN_CTRL, 32'h3, {30'h0, FAN_CTRL_SUPPRESS});
      @(posedge clk);
      fan_speed <= 16'h0000;
      settle();
      rd_chk(ADDR_MONITOR, 32'h3, 32'h0);
      rd_chk(4'hf, 32'hffff_ffff, 32'h0);
      // All four command pairs, both at once last
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         forward_run_command <= k[0];
         reverse_run_command <= k[1];
         settle();
         e = k[0] & k[1];
         rd_chk(ADDR_TERM_STATE, 32'h30, {26'h0, e, ~e, 4'h0});
         chk({31'h0, energized[2]}, {31'h0, ~e});
      end
      // Mid-run reset with commands released in the same cycle that srst rises, so no check sees a conflict
      @(posedge clk);
      forward_run_command <= 1'b0;
      reverse_run_command <= 1'b0;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd_chk(ADDR_COMB_THREE, 32'hffff_ffff, CFG_RESET);
      rd_chk(ADDR_TERM_SEL, 32'hffff_ffff, {14'h0, TERM_SEL_RESET});
      rd_chk(ADDR_FAN_CTRL, 32'h3, {30'h0, FAN_CTRL_RESET});
      rd_chk(ADDR_TERM_STATE, 32'h30, 32'h10);
      summarize();
   end
endmodule : output_status_logic_bench
